// ==== hdl/brake_burst_regs.svh ====
`ifndef BRAKE_BURST_REGS_SVH
`define BRAKE_BURST_REGS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define CTRL_ONE_OFS     8'h00
`define CHAN_EN_OFS      8'h20
`define BDT_OFS          8'h44
`define BURST_CTRL_OFS   8'h48
`define BURST_PORT_OFS   8'h4c
`define IRQ_STAT_OFS     8'h50
`define IRQ_MASK_OFS     8'h54

// ==========================================================
// Brake and dead-time control fields
`define BDT_DT_MSB       7
`define BDT_LOCK_MSB     9
`define BDT_LOCK_LSB     8
`define BDT_IDLE_OFF     10
`define BDT_RUN_OFF      11
`define BDT_BRK_EN       12
`define BDT_BRK_POL      13
`define BDT_AUTO_OE      14
`define BDT_MAIN_OE      15
`define LOCK_NONE        2'h0
`define LOCK_LVL1        2'h1
`define LOCK_LVL2        2'h2

// ==========================================================
// Burst control fields
`define BURST_BASE_MSB   4
`define BURST_LEN_MSB    12
`define BURST_LEN_LSB    8

// ==========================================================
// Channel enable fields, four bits per channel
`define CHEN_STRIDE      4
`define CHEN_OUT_EN      0
`define CHEN_OUT_POL     1
`define CHEN_COMPL_EN    2
`define CHEN_COMPL_POL   3

// ==========================================================
// Interrupt status bits
`define IRQ_BRAKE        0
`define IRQ_AUTO_OE      1
`define IRQ_BURST_DONE   2
`define IRQ_WIDTH        3

// ==========================================================
// Bus encodings
`define HTRANS_NONSEQ_BIT 1
`define HSIZE_BYTE       3'h0

`endif

// ==== hdl/brake_burst_pkg.sv ====
package brake_burst_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_READ = 2'b10
  } bus_state_t;

  typedef logic [15:0] half_t;

endpackage : brake_burst_pkg

// ==== hdl/regbank_if.sv ====
`timescale 1ns/1ns
interface regbank_if #(
  parameter int AW = 5
);
  logic                   we;
  logic [AW-1:0]          waddr;
  brake_burst_pkg::half_t wdata;
  logic [AW-1:0]          raddr;
  brake_burst_pkg::half_t rdata;

  modport ctrl (output we, waddr, wdata, raddr, input rdata);
  modport mem  (input we, waddr, wdata, raddr, output rdata);
endinterface : regbank_if

// ==== hdl/timer_regbank.sv ====
`timescale 1ns/1ns
module timer_regbank #(
  parameter int DEPTH = 32
) (
  input wire logic clk,
  regbank_if.mem   bank
);

  brake_burst_pkg::half_t mem_q [DEPTH];

  initial begin
    if (DEPTH != (1 << $bits(bank.raddr)))
      $error("timer_regbank: depth must match address width");
  end

  // ==========================================================
  // Storage; no reset, the words are plain timer registers
  always_ff @(posedge clk) begin
    if (bank.we) begin
      mem_q[bank.waddr] <= bank.wdata;
    end
  end

  // ==========================================================
  // Registered read, write-first so a read right after a write sees it
  always_ff @(posedge clk) begin
    if (bank.we && bank.waddr == bank.raddr) begin
      bank.rdata <= bank.wdata;
    end else begin
      bank.rdata <= mem_q[bank.raddr];
    end
  end

endmodule : timer_regbank

// ==== hdl/timer_brake_and_dma_burst.sv ====
// Function
// [RL1] Run mode: enabling a channel with off-state bit 1 drives inactive level
// [RL2] Brake polarity bit 0 makes low input active, 1 makes high active
// [RL3] New brake polarity takes effect one bus clock after the write
// [RL4] Auto enable sets main output enable at update when brake inactive
// [RL5] Main output enable 0 disables direct and complementary outputs
// [RL6] Main output enable 1 drives a channel only when its enables are set; code drives disabled channels at inactive level with run off-state 1
// [RL7] Active brake clears main output enable asynchronously when enabled
// [RL8] Lock level 1 or above ignores writes to brake and auto bits
// [RL9] Burst base field selects first target as offset from control one
// [RL10] Burst length field plus one is the number of transfers
// [RL11] Accesses to the burst port walk a burst of the set length
// [RL12] Each transfer targets control one plus base plus running index
// [RL13] Target byte address is four times base plus index; index auto-advances
// [RL14] Burst transfers may be 16-bit or 8-bit, same register count
// [RL15] 8-bit transfers put each byte in its own successive register
// [RL16] Reserved burst control bits read zero and ignore writes
`timescale 1ns/1ns
`include "brake_burst_regs.svh"
module timer_brake_and_dma_burst #(
  parameter int NCH = 4
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic [31:0]           hrdata,
  output logic                  hresp,
  input  wire logic             brake_input,
  input  wire logic             update_event,
  input  wire logic [NCH-1:0]   chan_ref,
  output logic [NCH-1:0]        channel_out,
  output logic [NCH-1:0]        channel_out_oe,
  output logic [NCH-1:0]        channel_out_compl,
  output logic [NCH-1:0]        channel_out_compl_oe,
  output logic                  main_output_en,
  output logic                  irq
);

  initial begin
    if (NCH < 1 || NCH > 4)
      $error("timer_brake_and_dma_burst: NCH must be 1 to 4");
  end

  // ==========================================================
  // Helpers
  function automatic logic [4:0] target_idx(input logic [4:0] base,
                                            input logic [4:0] idx);
    logic [5:0] sum;
    sum = {1'b0, base} + {1'b0, idx};
    return sum[4:0];
  endfunction : target_idx

  function automatic logic lock_at_least(input logic [1:0] lvl,
                                         input logic [1:0] min);
    return lvl >= min && lvl != `LOCK_NONE;
  endfunction : lock_at_least

  // ==========================================================
  // State
  brake_burst_pkg::bus_state_t state_reg;
  brake_burst_pkg::half_t      chan_en_reg;
  logic [7:0]                  deadtime_reg;
  logic [1:0]                  lock_reg;
  logic                        lock_written_reg;
  logic                        idle_off_state_sel_reg;
  logic                        run_off_state_sel_reg;
  logic                        brake_func_en_reg;
  logic                        brake_active_level_reg;
  logic                        pol_applied_reg;
  logic                        auto_output_en_reg;
  logic [4:0]                  burst_base_offset_reg;
  logic [4:0]                  burst_length_reg;
  logic [4:0]                  burst_idx_reg;
  logic [`IRQ_WIDTH-1:0]       irq_stat_reg;
  logic [`IRQ_WIDTH-1:0]       irq_mask_reg;
  logic                        brake_kill_seen_reg;
  logic                        wr_pend_reg;
  logic [7:0]                  wr_ofs_reg;
  logic                        wr_port_reg;
  logic                        wr_byte_reg;
  logic [1:0]                  wr_lane_reg;
  logic [4:0]                  wr_tgt_reg;
  logic [7:0]                  rd_ofs_reg;
  logic                        rd_mem_reg;

  regbank_if #(.AW(5)) bank ();

  timer_regbank #(
    .DEPTH (32)
  ) u_bank (
    .clk  (clk),
    .bank (bank.mem)
  );

  // ==========================================================
  // Address phase decode
  wire        addr_take  = hsel && htrans[`HTRANS_NONSEQ_BIT] && hready;
  wire [7:0]  addr_ofs   = {haddr[7:2], 2'b00};
  wire        addr_high  = |haddr[31:8];
  wire        take_rd    = addr_take && !hwrite;
  wire        take_wr    = addr_take && hwrite;
  wire        is_port    = !addr_high && addr_ofs == `BURST_PORT_OFS;
  wire        is_bank    = !addr_high && addr_ofs < `BDT_OFS
                           && addr_ofs != `CHAN_EN_OFS;
  wire [4:0]  port_tgt   = target_idx(burst_base_offset_reg,
                                      burst_idx_reg);  // [RL9] [RL12] [RL13]
  wire        port_take  = addr_take && is_port;
  wire        burst_last = burst_idx_reg == burst_length_reg;  // [RL10]

  // ==========================================================
  // Data phase write decode
  wire        wr_bdt   = wr_pend_reg && wr_ofs_reg == `BDT_OFS;
  wire        wr_bctl  = wr_pend_reg && wr_ofs_reg == `BURST_CTRL_OFS;
  wire        wr_chen  = wr_pend_reg && wr_ofs_reg == `CHAN_EN_OFS;
  wire        wr_stat  = wr_pend_reg && wr_ofs_reg == `IRQ_STAT_OFS;
  wire        wr_mask  = wr_pend_reg && wr_ofs_reg == `IRQ_MASK_OFS;
  wire        wr_bank  = wr_pend_reg && (wr_port_reg
                         || (wr_ofs_reg < `BDT_OFS
                             && wr_ofs_reg != `CHAN_EN_OFS));
  wire [7:0]  wr_byte  = hwdata[{wr_lane_reg, 3'b000} +: 8];
  wire        locked1  = lock_at_least(lock_reg, `LOCK_LVL1);  // [RL8]
  wire        locked2  = lock_at_least(lock_reg, `LOCK_LVL2);

  // Each byte transfer fills one register, so a 16-bit item sent MSB
  // first spreads over two successive registers
  assign bank.we    = wr_bank;
  assign bank.waddr = wr_port_reg ? wr_tgt_reg : wr_ofs_reg[6:2];
  assign bank.wdata = wr_byte_reg ? {8'h00, wr_byte}
                                  : hwdata[15:0];  // [RL14] [RL15]
  assign bank.raddr = is_port ? port_tgt : addr_ofs[6:2];

  // ==========================================================
  // Brake path
  // Polarity is applied from a copy one clock old, so a write never
  // reaches the comparator in the cycle it lands
  wire brake_act  = ~(brake_input ^ pol_applied_reg);  // [RL2] [RL3]
  wire brake_kill = brake_func_en_reg && brake_act;
  wire auto_set   = auto_output_en_reg && update_event
                    && !brake_act;  // [RL4]
  wire moe_next   = wr_bdt ? hwdata[`BDT_MAIN_OE]
                  : (auto_set ? 1'b1 : main_output_en);

  // The clear does not wait for a clock edge, but the channel outputs only
  // shut on the next clock edge after main_output_en falls
  always_ff @(posedge clk or negedge nrst or posedge brake_kill) begin
    if (!nrst) begin
      main_output_en <= 1'b0;
    end else if (brake_kill) begin
      main_output_en <= 1'b0;  // [RL7]
    end else begin
      main_output_en <= moe_next;
    end
  end

  // ==========================================================
  // Brake and dead-time control
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      deadtime_reg           <= '0;
      lock_reg               <= `LOCK_NONE;
      lock_written_reg       <= 1'b0;
      idle_off_state_sel_reg <= 1'b0;
      run_off_state_sel_reg  <= 1'b0;
      brake_func_en_reg      <= 1'b0;
      brake_active_level_reg <= 1'b0;
      auto_output_en_reg     <= 1'b0;
      pol_applied_reg        <= 1'b0;
    end else begin
      pol_applied_reg <= brake_active_level_reg;  // [RL3]
      if (wr_bdt) begin
        lock_written_reg <= 1'b1;
        if (!lock_written_reg) begin
          lock_reg <= hwdata[`BDT_LOCK_MSB:`BDT_LOCK_LSB];
        end
        if (!locked1) begin
          deadtime_reg           <= hwdata[`BDT_DT_MSB:0];
          brake_func_en_reg      <= hwdata[`BDT_BRK_EN];  // [RL8]
          brake_active_level_reg <= hwdata[`BDT_BRK_POL];  // [RL8]
          auto_output_en_reg     <= hwdata[`BDT_AUTO_OE];  // [RL8]
        end
        if (!locked2) begin
          idle_off_state_sel_reg <= hwdata[`BDT_IDLE_OFF];
          run_off_state_sel_reg  <= hwdata[`BDT_RUN_OFF];
        end
      end
    end
  end

  // ==========================================================
  // Burst control and running index
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      burst_base_offset_reg <= '0;
      burst_length_reg      <= '0;
      burst_idx_reg         <= '0;
    end else if (wr_bctl) begin
      burst_base_offset_reg <= hwdata[`BURST_BASE_MSB:0];  // [RL9] [RL16]
      burst_length_reg      <= hwdata[`BURST_LEN_MSB:`BURST_LEN_LSB];
      burst_idx_reg         <= '0;
    end else if (port_take) begin
      burst_idx_reg <= burst_last ? 5'h00
                                  : burst_idx_reg + 5'h01;  // [RL11] [RL13]
    end
  end

  // ==========================================================
  // Channel enables
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chan_en_reg <= 16'h0000;
    end else if (wr_chen) begin
      chan_en_reg <= hwdata[15:0];
    end
  end

  // ==========================================================
  // Channel outputs
  logic [NCH-1:0] out_next;
  logic [NCH-1:0] oe_next;
  logic [NCH-1:0] cout_next;
  logic [NCH-1:0] coe_next;

  always_comb begin
    out_next  = '0;
    oe_next   = '0;
    cout_next = '0;
    coe_next  = '0;
    for (int i = 0; i < NCH; i++) begin
      if (main_output_en) begin
        if (chan_en_reg[i*`CHEN_STRIDE + `CHEN_OUT_EN]) begin
          out_next[i] = chan_ref[i]
                        ^ chan_en_reg[i*`CHEN_STRIDE + `CHEN_OUT_POL];  // [RL6]
          oe_next[i]  = 1'b1;
        end else begin
          out_next[i] = chan_en_reg[i*`CHEN_STRIDE + `CHEN_OUT_POL];
          oe_next[i]  = run_off_state_sel_reg;  // [RL1]
        end
        if (chan_en_reg[i*`CHEN_STRIDE + `CHEN_COMPL_EN]) begin
          cout_next[i] = ~chan_ref[i]
                         ^ chan_en_reg[i*`CHEN_STRIDE + `CHEN_COMPL_POL];  // [RL6]
          coe_next[i]  = 1'b1;
        end else begin
          cout_next[i] = chan_en_reg[i*`CHEN_STRIDE + `CHEN_COMPL_POL];
          coe_next[i]  = run_off_state_sel_reg;  // [RL1]
        end
      end
    end
  end

  // Outputs follow the enable one clock later; a brake still stops
  // driving on the next edge even if the clock only just restarted
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      channel_out          <= '0;
      channel_out_oe       <= '0;
      channel_out_compl    <= '0;
      channel_out_compl_oe <= '0;
    end else begin
      channel_out          <= out_next;
      channel_out_oe       <= oe_next;  // [RL5]
      channel_out_compl    <= cout_next;
      channel_out_compl_oe <= coe_next;  // [RL5]
    end
  end

  // ==========================================================
  // Interrupts; a new event beats a clear in the same cycle
  wire [`IRQ_WIDTH-1:0] irq_events = {port_take && burst_last,
                                      auto_set && !main_output_en,
                                      brake_kill && !brake_kill_seen_reg};
  wire [`IRQ_WIDTH-1:0] irq_clear  = wr_stat ? hwdata[`IRQ_WIDTH-1:0]
                                             : '0;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat_reg        <= '0;
      irq_mask_reg        <= '0;
      brake_kill_seen_reg <= 1'b0;
      irq                 <= 1'b0;
    end else begin
      brake_kill_seen_reg <= brake_kill;
      irq_stat_reg        <= (irq_stat_reg & ~irq_clear) | irq_events;
      if (wr_mask) begin
        irq_mask_reg <= hwdata[`IRQ_WIDTH-1:0];
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ==========================================================
  // Bus data phase tracking
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_reg <= 1'b0;
      wr_ofs_reg  <= 8'h00;
      wr_port_reg <= 1'b0;
      wr_byte_reg <= 1'b0;
      wr_lane_reg <= 2'h0;
      wr_tgt_reg  <= 5'h00;
    end else begin
      wr_pend_reg <= take_wr && !addr_high;
      if (take_wr) begin
        wr_ofs_reg  <= addr_ofs;
        wr_port_reg <= is_port;
        wr_byte_reg <= hsize == `HSIZE_BYTE;
        wr_lane_reg <= haddr[1:0];
        wr_tgt_reg  <= port_tgt;
      end
    end
  end

  // ==========================================================
  // Read answer, one wait state while the bank word is fetched
  wire brake_burst_pkg::half_t bdt_word = {main_output_en,
    auto_output_en_reg, brake_active_level_reg, brake_func_en_reg,
    run_off_state_sel_reg, idle_off_state_sel_reg, lock_reg,
    deadtime_reg};
  wire brake_burst_pkg::half_t bctl_word = {3'h0, burst_length_reg,
    3'h0, burst_base_offset_reg};  // [RL16]
  wire brake_burst_pkg::half_t rd_word =
      rd_mem_reg                      ? bank.rdata
    : rd_ofs_reg == `BDT_OFS        ? bdt_word
    : rd_ofs_reg == `BURST_CTRL_OFS ? bctl_word
    : rd_ofs_reg == `CHAN_EN_OFS    ? chan_en_reg
    : rd_ofs_reg == `IRQ_STAT_OFS   ? {13'h0000, irq_stat_reg}
    : rd_ofs_reg == `IRQ_MASK_OFS   ? {13'h0000, irq_mask_reg}
    : 16'h0000;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg  <= brake_burst_pkg::ST_IDLE;
      hreadyout  <= 1'b1;
      hrdata     <= 32'h0000_0000;
      hresp      <= 1'b0;
      rd_ofs_reg <= 8'h00;
      rd_mem_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        brake_burst_pkg::ST_IDLE: begin
          if (take_rd) begin
            state_reg  <= brake_burst_pkg::ST_READ;
            hreadyout  <= 1'b0;
            rd_ofs_reg <= addr_high ? 8'hff : addr_ofs;
            rd_mem_reg <= is_bank || is_port;
          end
        end
        brake_burst_pkg::ST_READ: begin
          state_reg <= brake_burst_pkg::ST_IDLE;
          hreadyout <= 1'b1;
          hrdata    <= {16'h0000, rd_word};
        end
      endcase
    end
  end

endmodule : timer_brake_and_dma_burst

// ==== tb/timer_brake_and_dma_burst_props.sv ====
`timescale 1ns/1ns
`include "brake_burst_regs.svh"
// ====================
// Port checker
module timer_brake_and_dma_burst_props #(
  parameter int NCH = 4
) (
  input wire logic           clk,
  input wire logic           nrst,
  input wire logic           hsel,
  input wire logic [31:0]    haddr,
  input wire logic [1:0]     htrans,
  input wire logic           hwrite,
  input wire logic [31:0]    hwdata,
  input wire logic           hready,
  input wire logic           hreadyout,
  input wire logic [31:0]    hrdata,
  input wire logic           hresp,
  input wire logic           brake_input,
  input wire logic           update_event,
  input wire logic [NCH-1:0] chan_ref,
  input wire logic [NCH-1:0] channel_out,
  input wire logic [NCH-1:0] channel_out_oe,
  input wire logic [NCH-1:0] channel_out_compl_oe,
  input wire logic           main_output_en
);
  logic        ap_w;
  logic [7:0]  ap_a;
  logic        lk_set;
  logic [15:0] bdt_sh;
  logic [15:0] chen_sh;
  wire         rd_req = hsel && htrans[1] && hready && !hwrite;
  wire         wr_dp  = ap_w && hready;
  wire         wr_bdt = wr_dp && ap_a == `BDT_OFS;
  // Bits kept on a write: the lock field is write-once
  wire [15:0]  bdt_keep = !lk_set ? 16'h0000 :
                          bdt_sh[9:8] == 2'h0 ? 16'h0300 :
                          bdt_sh[9:8] == 2'h1 ? 16'h73ff : 16'h7fff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ap_w <= 1'b0;
      ap_a <= 8'h00;
      lk_set <= 1'b0;
      bdt_sh <= 16'h0000;
      chen_sh <= 16'h0000;
    end else begin
      if (hready) begin
        ap_w <= hsel && htrans[1] && hwrite && haddr[31:8] == 24'h0;
        ap_a <= haddr[7:0];
      end
      if (wr_bdt) begin
        bdt_sh <= (bdt_sh & bdt_keep) | (hwdata[15:0] & ~bdt_keep);
        lk_set <= 1'b1;
      end
      if (wr_dp && ap_a == `CHAN_EN_OFS) begin
        chen_sh <= hwdata[15:0];
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // ====================
  // Assertions
  a_moe_off_quiet: assert property (!main_output_en |=>
    channel_out_oe == '0 && channel_out_compl_oe == '0)
    else $error("outputs driven while off");
  a_chan_drive: assert property (main_output_en && chen_sh[0] |=>
    channel_out_oe[0] && channel_out[0] == $past(chan_ref[0] ^ chen_sh[1]))
    else $error("channel not driven");
  a_run_off_state: assert property (main_output_en && !chen_sh[0] |=>
    channel_out_oe[0] == $past(bdt_sh[11]))
    else $error("run off-state ignored");
  a_brake_trip: assert property (bdt_sh[12] &&
    brake_input == bdt_sh[13] && $stable(bdt_sh[13]) |-> !main_output_en)
    else $error("brake did not trip");
  a_auto_set: assert property (bdt_sh[14] && update_event && !wr_bdt &&
    brake_input != bdt_sh[13] && $stable(bdt_sh[13]) |=>
    main_output_en || brake_input == bdt_sh[13])
    else $error("auto set missed");
  a_no_auto: assert property (!bdt_sh[14] && !main_output_en && !wr_bdt
    |=> !main_output_en)
    else $error("set without software");
  a_read_wait: assert property (rd_req |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response");
  a_resv_zero: assert property (rd_req && haddr == {24'h0,
    `BURST_CTRL_OFS} |-> ##2 hrdata[15:13] == 3'h0 && hrdata[7:5] == 3'h0)
    else $error("reserved bits set");

  c_trip: cover property (bdt_sh[12] && $fell(main_output_en));
  c_auto: cover property (bdt_sh[14] && update_event ##1 main_output_en);
  c_port: cover property (hsel && htrans[1] && haddr[7:0] == `BURST_PORT_OFS);
endmodule : timer_brake_and_dma_burst_props

bind timer_brake_and_dma_burst timer_brake_and_dma_burst_props #(.NCH(NCH))
  props_u (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hreadyout, .hrdata, .hresp, .brake_input, .update_event, .chan_ref,
  .channel_out, .channel_out_oe, .channel_out_compl_oe, .main_output_en);

// ==== tb/dma_brake_partner.sv ====
`timescale 1ns/1ns
`include "brake_burst_regs.svh"
// ====================
// Bus master, burst source and brake pin
module dma_brake_partner (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  output logic             brake_input,
  output logic             update_event
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    brake_input = 1'b1;
    update_event = 1'b0;
  end

  task automatic wait_ready();
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
  endtask : wait_ready

  // Stale write data is inverted so a missed data phase cannot pass
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d, input logic [2:0] sz,
                      output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    htrans <= 2'h2;
    hwdata <= ~hwdata;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    r = hrdata;
  endtask : xfer

  task automatic burst16(input int n, input logic [15:0] v);
    logic [31:0] r;
    for (int i = 0; i < n; i++) begin
      xfer(1'b1, {24'h0, `BURST_PORT_OFS}, {16'h0, v + 16'(i)}, 3'h2, r);
    end
  endtask : burst16

  // Byte mode: upper half of the item first, then the lower half
  task automatic burst8(input logic [15:0] v);
    logic [31:0] r;
    xfer(1'b1, {24'h0, `BURST_PORT_OFS}, {24'h0, v[15:8]}, 3'h0, r);
    xfer(1'b1, {24'h0, `BURST_PORT_OFS}, {24'h0, v[7:0]}, 3'h0, r);
  endtask : burst8

  task automatic set_brake(input logic v);
    @(posedge clk);
    brake_input <= v;
  endtask : set_brake

  task automatic pulse_update();
    @(posedge clk);
    update_event <= 1'b1;
    @(posedge clk);
    update_event <= 1'b0;
  endtask : pulse_update
endmodule : dma_brake_partner

// ==== tb/timer_brake_and_dma_burst_tb.sv ====
`timescale 1ns/1ns
`include "brake_burst_regs.svh"
module timer_brake_and_dma_burst_tb;
  logic        clk, nrst, hsel, hwrite, hreadyout, hresp, brake_input;
  logic        update_event, main_output_en, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  chan_ref, channel_out, channel_out_oe;
  logic [3:0]  channel_out_compl, channel_out_compl_oe;
  wire         hready = hreadyout;
  wire  [15:0] outs = {channel_out_oe, channel_out_compl_oe, channel_out,
                       channel_out_compl};
  int          num_errors, compares;

  // ====================
  // Clock, design and partner
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  timer_brake_and_dma_burst dut_u (.clk, .nrst, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp,
    .brake_input, .update_event, .chan_ref, .channel_out, .channel_out_oe,
    .channel_out_compl, .channel_out_compl_oe, .main_output_en, .irq);
  dma_brake_partner partner_u (.clk, .hready, .hrdata, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .brake_input, .update_event);

  // ====================
  // Helpers
  task automatic chk(input logic [31:0] got, exp, input string m);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    partner_u.xfer(1'b1, {24'h0, a}, d, 3'h2, rd);
  endtask : wr
  task automatic rdc(input logic [31:0] a, exp, input string m);
    partner_u.xfer(1'b0, a, 32'h0, 3'h2, rd);
    chk(rd, exp, m);
  endtask : rdc
  task automatic settle();
    @(posedge clk);
    #1;
  endtask : settle

  // ====================
  // Scenarios
  task automatic t_map();
    rdc(`BDT_OFS, 32'h0, "bdt reset");
    rdc(`BURST_CTRL_OFS, 32'h0, "burst ctrl reset");
    rdc(32'h100, 32'h0, "unmapped read");
    wr(`BURST_CTRL_OFS, 32'hffff_ffff);
    rdc(`BURST_CTRL_OFS, 32'h1f1f, "reserved bits");
  endtask : t_map

  task automatic t_burst();
    wr(`BURST_CTRL_OFS, 32'h1100);
    partner_u.burst16(17, 16'h0100);
    rdc(`IRQ_STAT_OFS, 32'h0, "done before last");
    partner_u.burst16(1, 16'h0200);
    rdc(`IRQ_STAT_OFS, 32'h4, "done after 18");
    chk(32'(irq), 32'h0, "masked irq");
    wr(`IRQ_MASK_OFS, 32'h4);
    settle();
    chk(32'(irq), 32'h1, "unmasked irq");
    wr(`IRQ_STAT_OFS, 32'h4);
    settle();
    chk(32'(irq), 32'h0, "irq cleared");
    wr(`BURST_CTRL_OFS, 32'h0202);
    partner_u.burst16(3, 16'h1230);
    for (int i = 0; i < 3; i++) begin
      rdc(32'h8 + 32'(4 * i), 32'h1230 + 32'(i), "burst word");
    end
    partner_u.burst16(1, 16'h5555);
    rdc(32'h8, 32'h5555, "index wrap");
    wr(`BURST_CTRL_OFS, 32'h0101);
    partner_u.burst8(16'habcd);
    rdc(32'h4, 32'hab, "byte high");
    rdc(32'h8, 32'hcd, "byte low");
  endtask : t_burst

  task automatic t_outputs();
    chan_ref <= 4'h1;
    wr(`CHAN_EN_OFS, 32'h5);
    wr(`BDT_OFS, 32'h8800);
    settle();
    chk(32'(outs), 32'hff10, "run off 1");
    wr(`BDT_OFS, 32'h8000);
    settle();
    chk(32'(outs), 32'h1110, "run off 0");
    wr(`BDT_OFS, 32'h0);
    settle();
    chk(32'(outs[15:8]), 32'h0, "idle");
  endtask : t_outputs

  task automatic t_brake();
    wr(`BDT_OFS, 32'h9000);
    partner_u.set_brake(1'b0);
    #1;
    chk(32'(main_output_en), 32'h0, "async trip");
    rdc(`IRQ_STAT_OFS, 32'h5, "trip status");
    partner_u.set_brake(1'b1);
    wr(`IRQ_STAT_OFS, 32'h1);
    wr(`BDT_OFS, 32'h5000);
    settle();
    chk(32'(main_output_en), 32'h0, "no set before update");
    partner_u.pulse_update();
    #1;
    chk(32'(main_output_en), 32'h1, "auto set");
    partner_u.set_brake(1'b0);
    partner_u.pulse_update();
    #1;
    chk(32'(main_output_en), 32'h0, "no auto set in brake");
    partner_u.set_brake(1'b1);
    wr(`BDT_OFS, 32'hf000);
    #1;
    chk(32'(main_output_en), 32'h1, "old polarity held");
    settle();
    chk(32'(main_output_en), 32'h0, "new polarity trips");
  endtask : t_brake

  task automatic t_lock();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    wr(`BDT_OFS, 32'h0100);
    wr(`BDT_OFS, 32'hf0ff);
    rdc(`BDT_OFS, 32'h8100, "locked bits");
  endtask : t_lock

  // ====================
  // Run control
  task automatic report_and_stop();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  initial begin
    #100000;
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    nrst = 1'b0;
    chan_ref = 4'h0;
    num_errors = 0;
    compares = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_map();
    t_burst();
    t_outputs();
    t_brake();
    t_lock();
    report_and_stop();
  end
endmodule : timer_brake_and_dma_burst_tb
